//--- hw/pcsc_top.v
// Program counter and return stack sequencing
// Summary of operation
// - The program counter steps by one after each executed instruction.
// - Jumps, calls, interrupts and reset load a target address directly.
// - A taken skip discards the prefetched instruction with one bubble.
// - Return addresses live in the 256-byte data RAM, up to 124 levels.
// - The stack pointer is internal and not visible to software.
// - Calls push the program counter plus one; interrupt acknowledges push the current program counter.
// - Both return instructions reload the program counter from the stack.
// - Reset sets the stack pointer to 0x07.
// - A full stack holds off the interrupt acknowledge, request kept.
// - After a return leaves the full state the held interrupt is served.
// - Calls are never blocked by a full stack and may overflow.
// - Reset starts execution at address 0000H.
// - Fetch overlaps execute; branches and calls take extra cycles.
`timescale 1ns/1ns
`default_nettype none
`include "pcsc_consts.vh"
module pcsc_top #(
   parameter PC_W = `PCSC_PC_W,
   parameter SP_W = `PCSC_SP_W
) (
   input wire clk,
   input wire rst_n,
   input wire instr_done,
   input wire jump_req,
   input wire [PC_W-1:0] jump_target,
   input wire call_req,
   input wire [PC_W-1:0] call_target,
   input wire skip_taken,
   input wire routine_exit_instr,
   input wire irq_routine_exit_instr,
   input wire irq_pending,
   input wire [PC_W-1:0] irq_vector,
   output reg irq_ack,
   output wire [PC_W-1:0] pc,
   output wire fetch_valid,
   output wire busy,
   output wire stack_full,
   output wire ram_we,
   output wire ram_re,
   output wire [SP_W-1:0] ram_addr,
   output wire [7:0] ram_wdata,
   input wire [7:0] ram_rdata
);
   // ***************************************
   // Reset release
   // ***************************************
   reg rst_s1_ff;
   reg rst_s2_ff;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= rst_s1_ff;
      end
   end
   wire srst_n = rst_s2_ff;
   // ***************************************
   // State codes
   // ***************************************
   localparam [2:0] ST_RUN = `PCSC_ST_RUN;
   localparam [2:0] ST_PUSH_HI = `PCSC_ST_PUSH_HI;
   localparam [2:0] ST_POP_LO = `PCSC_ST_POP_LO;
   localparam [2:0] ST_POP_WAIT = `PCSC_ST_POP_WAIT;
   localparam [2:0] ST_BUBBLE = `PCSC_ST_BUBBLE;
   // ***************************************
   // State and registers
   // ***************************************
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [PC_W-1:0] pc_ff;
   reg [PC_W-1:0] nxt_pc;
   reg [PC_W-1:0] ret_ff;
   reg [PC_W-1:0] nxt_ret;
   reg [7:0] pop_hi_ff;
   reg [7:0] nxt_pop_hi;
   reg sp_inc;
   reg sp_dec;
   reg we;
   reg re;
   reg [7:0] wdata;
   reg [SP_W-1:0] addr;
   wire [SP_W-1:0] sp;
   wire full;
   pcsc_stack_ptr #(
      .SP_W(SP_W)
   ) u_sp (
      .clk(clk),
      .rst_n(srst_n),
      .inc(sp_inc),
      .dec(sp_dec),
      .sp(sp),
      .full(full)
   );
   function [SP_W-1:0] sp_plus;
      input [SP_W-1:0] v;
      begin
         sp_plus = v + `PCSC_ONE_SP;
      end
   endfunction
   function [PC_W-1:0] pc_plus;
      input [PC_W-1:0] v;
      begin
         pc_plus = v + `PCSC_ONE_PC;
      end
   endfunction
   function [7:0] lo_byte;
      input [PC_W-1:0] v;
      begin
         lo_byte = v[`PCSC_BYTE_W-1:0];
      end
   endfunction
   function [7:0] hi_byte;
      input [PC_W-1:0] v;
      begin
         hi_byte = v[PC_W-1:`PCSC_BYTE_W];
      end
   endfunction
   wire is_return = routine_exit_instr | irq_routine_exit_instr;
   wire in_run = (state_ff == ST_RUN);
   // ***************************************
   // Sequencing
   // ***************************************
   always @* begin
      nxt_state = state_ff;
      nxt_pc = pc_ff;
      nxt_ret = ret_ff;
      nxt_pop_hi = pop_hi_ff;
      sp_inc = 1'b0;
      sp_dec = 1'b0;
      we = 1'b0;
      re = 1'b0;
      wdata = 8'h00;
      addr = sp;
      irq_ack = 1'b0;
      case (state_ff)
         ST_RUN: begin
            if (!srst_n) begin
               nxt_state = ST_RUN;
            end else if (irq_pending && !full) begin
               irq_ack = 1'b1;
               nxt_ret = pc_ff;
               nxt_pc = irq_vector;
               we = 1'b1;
               addr = sp_plus(sp);
               wdata = lo_byte(pc_ff);
               sp_inc = 1'b1;
               nxt_state = ST_PUSH_HI;
            end else if (instr_done && call_req) begin
               nxt_ret = pc_plus(pc_ff);
               nxt_pc = call_target;
               we = 1'b1;
               addr = sp_plus(sp);
               wdata = lo_byte(nxt_ret);
               sp_inc = 1'b1;
               nxt_state = ST_PUSH_HI;
            end else if (instr_done && is_return) begin
               re = 1'b1;
               addr = sp;
               sp_dec = 1'b1;
               nxt_state = ST_POP_LO;
            end else if (instr_done && jump_req) begin
               nxt_pc = jump_target;
               nxt_state = ST_BUBBLE;
            end else if (instr_done && skip_taken) begin
               nxt_pc = pc_plus(pc_plus(pc_ff));
               nxt_state = ST_BUBBLE;
            end else if (instr_done) begin
               nxt_pc = pc_plus(pc_ff);
            end
         end
         ST_PUSH_HI: begin
            we = 1'b1;
            addr = sp_plus(sp);
            wdata = hi_byte(ret_ff);
            sp_inc = 1'b1;
            nxt_state = ST_BUBBLE;
         end
         ST_POP_LO: begin
            nxt_pop_hi = ram_rdata;
            re = 1'b1;
            addr = sp;
            sp_dec = 1'b1;
            nxt_state = ST_POP_WAIT;
         end
         ST_POP_WAIT: begin
            nxt_pc = {pop_hi_ff, ram_rdata};
            nxt_state = ST_BUBBLE;
         end
         ST_BUBBLE: begin
            nxt_state = ST_RUN;
         end
         default: begin
            nxt_state = ST_RUN;
         end
      endcase
   end
   always @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         state_ff <= ST_RUN;
         pc_ff <= `PCSC_RESET_PC;
         ret_ff <= `PCSC_RESET_PC;
         pop_hi_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         pc_ff <= nxt_pc;
         ret_ff <= nxt_ret;
         pop_hi_ff <= nxt_pop_hi;
      end
   end
   assign pc = pc_ff;
   assign fetch_valid = in_run & srst_n;
   assign busy = ~in_run;
   assign stack_full = full;
   assign ram_we = we;
   assign ram_re = re;
   assign ram_addr = addr;
   assign ram_wdata = wdata;
endmodule // pcsc_top
`default_nettype wire

//--- hw/pcsc_consts.vh
// Constants for the program counter and stack control block
`ifndef PCSC_CONSTS_VH
`define PCSC_CONSTS_VH
`define PCSC_PC_W 16
`define PCSC_SP_W 8
`define PCSC_BYTE_W 8
`define PCSC_RESET_PC 16'h0000
`define PCSC_RESET_SP 8'h07
`define PCSC_SP_FULL 8'hff
`define PCSC_ONE_PC 16'h0001
`define PCSC_ONE_SP 8'h01
`define PCSC_ST_RUN 3'h0
`define PCSC_ST_PUSH_HI 3'h1
`define PCSC_ST_POP_LO 3'h2
`define PCSC_ST_POP_WAIT 3'h3
`define PCSC_ST_BUBBLE 3'h4
`endif

//--- hw/pcsc_stack_ptr.v
// Hidden stack pointer with full flag
`timescale 1ns/1ns
`default_nettype none
`include "pcsc_consts.vh"
module pcsc_stack_ptr #(
   parameter SP_W = `PCSC_SP_W
) (
   input wire clk,
   input wire rst_n,
   input wire inc,
   input wire dec,
   output wire [SP_W-1:0] sp,
   output wire full
);
   reg [SP_W-1:0] stack_pointer_ff;
   reg [SP_W-1:0] nxt_stack_pointer;
   always @* begin
      nxt_stack_pointer = stack_pointer_ff;
      if (inc) begin
         nxt_stack_pointer = stack_pointer_ff + `PCSC_ONE_SP;
      end else if (dec) begin
         nxt_stack_pointer = stack_pointer_ff - `PCSC_ONE_SP;
      end
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stack_pointer_ff <= `PCSC_RESET_SP;
      end else begin
         stack_pointer_ff <= nxt_stack_pointer;
      end
   end
   assign sp = stack_pointer_ff;
   assign full = (stack_pointer_ff == `PCSC_SP_FULL);
endmodule // pcsc_stack_ptr
`default_nettype wire

//--- test/pcsc_chk_sva.sv
// Stack sequencing checker
`timescale 1ns/1ns
`default_nettype none
module pcsc_chk (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic instr_done,
   input wire logic call_req,
   input wire logic routine_exit_instr,
   input wire logic irq_routine_exit_instr,
   input wire logic irq_pending,
   input wire logic irq_ack,
   input wire logic fetch_valid,
   input wire logic busy,
   input wire logic stack_full,
   input wire logic ram_we,
   input wire logic ram_re,
   input wire logic [7:0] ram_addr,
   input wire logic [7:0] ram_wdata,
   input wire logic [15:0] pc
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic go = fetch_valid & instr_done & ~irq_ack;
   wire logic is_ret = routine_exit_instr | irq_routine_exit_instr;
   wire logic [15:0] ret_addr = pc + 16'h0001;
   a_call_data: assert property (go && call_req |->
      ram_wdata == ret_addr[7:0] ##1 ram_wdata == $past(ret_addr[15:8]))
      else $error("push data");
   a_ack_data: assert property (irq_ack |-> ram_wdata == pc[7:0] ##1
      ram_wdata == $past(pc[15:8])) else $error("ack data");
   a_call_push: assert property (go && call_req |-> ram_we ##1
      ram_we && ram_addr == $past(ram_addr) + 8'h01 ##1 busy ##1 fetch_valid)
      else $error("push");
   a_ret_pop: assert property (go && !call_req && is_ret
      |-> ram_re ##1 ram_re ##1 busy [*2] ##1 fetch_valid) else $error("pop");
   a_ack_push: assert property (irq_ack |-> ram_we ##1 ram_we ##1 busy)
      else $error("ack");
   a_full_hold: assert property (stack_full |-> !irq_ack)
      else $error("hold");
   a_ack_free: assert property (fetch_valid && irq_pending && !stack_full
      |-> irq_ack) else $error("serve");
   a_call_ovf: assert property (go && call_req && stack_full
      |-> ram_addr == 8'h00) else $error("wrap");
   a_full_set: assert property (ram_we && ram_addr == 8'hff
      |=> stack_full) else $error("set");
   a_full_clr: assert property (ram_re && ram_addr == 8'hff
      |=> !stack_full) else $error("clear");
   c_ovf: cover property (go && call_req && stack_full);
   c_held: cover property (stack_full && irq_pending);
   c_pop: cover property (ram_re);
   c_served: cover property (irq_ack);
endmodule // pcsc_chk
bind pcsc_top pcsc_chk pcsc_chk_i (
   .clk(clk),
   .rst_n(rst_n),
   .instr_done(instr_done),
   .call_req(call_req),
   .routine_exit_instr(routine_exit_instr),
   .irq_routine_exit_instr(irq_routine_exit_instr),
   .irq_pending(irq_pending),
   .irq_ack(irq_ack),
   .fetch_valid(fetch_valid),
   .busy(busy),
   .stack_full(stack_full),
   .ram_we(ram_we),
   .ram_re(ram_re),
   .ram_addr(ram_addr),
   .ram_wdata(ram_wdata),
   .pc(pc)
);
`default_nettype wire

//--- test/pcsc_ram_model.sv
// Data RAM model for the return stack
`timescale 1ns/1ns
`default_nettype none
module pcsc_ram_model (
   input wire logic clk, ram_we, ram_re,
   input wire logic [7:0] ram_addr, ram_wdata,
   output logic [7:0] ram_rdata = 8'h00);
   logic [7:0] mem [256];
   // Stale data is inverted
   always @(posedge clk) begin
      if (ram_we) mem[ram_addr] <= ram_wdata;
      ram_rdata <= ram_re ? mem[ram_addr] : ~ram_rdata;
   end
endmodule // pcsc_ram_model
`default_nettype wire

//--- test/tb_top.sv
// Stack sequencing bench
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk = 1'b0, rst_n = 1'b0, irq_ack, fetch_valid, busy, stack_full;
   logic instr_done, call_req, routine_exit_instr, irq_routine_exit_instr;
   logic irq_pending, jump_req, skip_taken, ram_we, ram_re;
   logic [6:0] kind = 7'h00;
   logic [7:0] ram_addr, ram_wdata, ram_rdata;
   logic [15:0] jump_target = 16'h0000, call_target, irq_vector, pc;
   int fail_count = 0, cmp_count = 0, n;
   assign {irq_pending, instr_done, call_req, routine_exit_instr,
      irq_routine_exit_instr, jump_req, skip_taken} = kind;
   assign {call_target, irq_vector} = {jump_target, 16'h0300};
   pcsc_top pcsc_top_i (
      .clk(clk),
      .rst_n(rst_n),
      .instr_done(instr_done),
      .jump_req(jump_req),
      .jump_target(jump_target),
      .call_req(call_req),
      .call_target(call_target),
      .skip_taken(skip_taken),
      .routine_exit_instr(routine_exit_instr),
      .irq_routine_exit_instr(irq_routine_exit_instr),
      .irq_pending(irq_pending),
      .irq_vector(irq_vector),
      .irq_ack(irq_ack),
      .pc(pc),
      .fetch_valid(fetch_valid),
      .busy(busy),
      .stack_full(stack_full),
      .ram_we(ram_we),
      .ram_re(ram_re),
      .ram_addr(ram_addr),
      .ram_wdata(ram_wdata),
      .ram_rdata(ram_rdata)
   );
   pcsc_ram_model pcsc_ram_model_i (
      .clk(clk),
      .ram_we(ram_we),
      .ram_re(ram_re),
      .ram_addr(ram_addr),
      .ram_wdata(ram_wdata),
      .ram_rdata(ram_rdata)
   );
   always #20 clk = ~clk;
   task summarize();
      if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(string s, logic [15:0] e, g);
      cmp_count++;
      if (g !== e) $display("MISMATCH %s exp %h got %h", s, e, g);
      if (g !== e) fail_count++;
   endtask
   task wait_idle();
      for (n = 0; busy === 1'b1 && n < 8; n++)
         @(negedge clk);
      chk("busy", 16'h0000, {15'h0000, busy});
      if (busy !== 1'b0) summarize();
   endtask
   // One request cycle, entered a full clock after the last one
   task run(logic [6:0] k, logic [15:0] t);
      @(negedge clk);
      kind = k;
      jump_target = t;
      @(negedge clk);
      kind = 7'h00;
      wait_idle();
   endtask
   task t_flow();
      chk("pc", 16'h0000, pc);
      run(7'h20, 16'h0000);
      chk("pc", 16'h0001, pc);
      run(7'h21, 16'h0000);
      chk("pc", 16'h0003, pc);
      run(7'h22, 16'h4a5c);
      chk("pc", 16'h4a5c, pc);
      run(7'h30, 16'h2000);
      run(7'h28, 16'h0000);
      chk("pc", 16'h4a5d, pc);
   endtask
   task t_full();
      repeat (124) run(7'h30, 16'h1000);
      chk("full", 16'h0001, {15'h0000, stack_full});
      run(7'h40, 16'h0000);
      chk("pc", 16'h1000, pc);
      // Interrupt stays pending across the return
      @(negedge clk);
      kind = 7'h64;
      @(negedge clk);
      kind = 7'h40;
      for (n = 0; irq_ack !== 1'b1 && n < 8; n++)
         @(negedge clk);
      chk("pc", 16'h1001, pc);
      chk("ack", 16'h0001, {15'h0000, irq_ack});
      if (irq_ack !== 1'b1) summarize();
      @(negedge clk);
      kind = 7'h00;
      wait_idle();
      chk("pc", 16'h0300, pc);
      run(7'h30, 16'h0800);
      chk("full", 16'h0000, {15'h0000, stack_full});
      chk("pc", 16'h0800, pc);
   endtask
   task t_reset();
      @(negedge clk);
      rst_n = 1'b0;
      kind = 7'h70;
      @(negedge clk);
      chk("pc", 16'h0000, pc);
      chk("we", 16'h0000, {15'h0000, ram_we});
      chk("ack", 16'h0000, {15'h0000, irq_ack});
      kind = 7'h00;
      @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      kind = 7'h30;
      jump_target = 16'h0040;
      #10 chk("addr", 16'h0008, {8'h00, ram_addr});
      @(negedge clk);
      kind = 7'h00;
      wait_idle();
      chk("pc", 16'h0040, pc);
      run(7'h28, 16'h0000);
      chk("pc", 16'h0001, pc);
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      t_flow();
      t_full();
      t_reset();
      summarize();
   end
endmodule // tb_top
`default_nettype wire
